// ==== hw/sbio_map.vh ====
// Purpose: constants for the scripted byte i/o port
// Assumes: 200 MHz aclk, 32-bit axi4-lite data, 8-bit byte address
// Notes:   definitions only
`ifndef SBIO_MAP_VH
`define SBIO_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define SBIO_OFF_CTRL     8'h00
`define SBIO_OFF_STATUS   8'h04
`define SBIO_OFF_LEN      8'h08
`define SBIO_OFF_PINS     8'h0C
`define SBIO_OFF_SCRIPT   8'h40
`define SBIO_OFF_RESULT   8'h80
`define SBIO_WIN_MASK     8'hC0

////////////////////////////////////////////////////////////////////////////////
// field positions
`define SBIO_CTRL_START   0
`define SBIO_ST_BUSY      0
`define SBIO_ST_DONE      1
`define SBIO_ST_ERR       2
`define SBIO_OPC_HI       31
`define SBIO_OPC_LO       28
`define SBIO_PORT_HI      27
`define SBIO_PORT_LO      24
`define SBIO_LINE_HI      18
`define SBIO_LINE_LO      16
`define SBIO_ARG_HI       15
`define SBIO_ARG_LO       0

////////////////////////////////////////////////////////////////////////////////
// command opcodes
`define SBIO_OP_DELAY_MS  4'h1
`define SBIO_OP_CFG_LINE  4'h2
`define SBIO_OP_CFG_PORT  4'h3
`define SBIO_OP_RD_LINE   4'h4
`define SBIO_OP_WR_PORT   4'h5

////////////////////////////////////////////////////////////////////////////////
// sizes, reset values, answers
`define SBIO_DEPTH        5'h10
`define SBIO_PORT_ZERO    4'h0
`define SBIO_BYTE_ZERO    8'h00
`define SBIO_WORD_ZERO    32'h0000_0000
`define SBIO_RESP_OKAY    2'h0
`define SBIO_RESP_SLVERR  2'h2

////////////////////////////////////////////////////////////////////////////////
// timing: one millisecond in ns and the clock period in ns
`define SBIO_MS_NS        1000000
`define SBIO_CLK_NS       5
`define SBIO_MS_CYCLES    (`SBIO_MS_NS / `SBIO_CLK_NS)

`endif

// ==== hw/sbio_ms_timer.v ====
// Purpose: millisecond wait timer for the script sequencer
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes:   busy rises the edge after start and lasts ms_count * cyc_per_ms cycles
`include "sbio_map.vh"

module sbio_ms_timer #(
  parameter [31:0] CYC_PER_MS = `SBIO_MS_CYCLES
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // request
  input  wire        start,
  input  wire [15:0] ms_count,
  // state
  output reg         busy_q
);

  reg [15:0] ms_left_q;
  reg [31:0] cyc_q;

  ////////////////////////////////////////////////////////////////////////////////
  // a zero count never raises busy, so the script moves straight on
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_q    <= 1'b0;
      ms_left_q <= 16'h0000;
      cyc_q     <= 32'h0000_0000;
    end
    else if (start && !busy_q)
    begin
      busy_q    <= (ms_count != 16'h0000);
      ms_left_q <= ms_count;
      cyc_q     <= 32'h0000_0000;
    end
    else if (busy_q)
    begin
      if (cyc_q == CYC_PER_MS - 32'h0000_0001)
      begin
        cyc_q     <= 32'h0000_0000;
        ms_left_q <= ms_left_q - 16'h0001;
        if (ms_left_q == 16'h0001)
          busy_q <= 1'b0;
      end
      else
        cyc_q <= cyc_q + 32'h0000_0001;
    end
  end

endmodule // sbio_ms_timer

// ==== hw/sbio_port.v ====
// Purpose: byte-wide gpio port run by a stored command script, axi4-lite slave
// Assumes: gpio_in synchronous to aclk; single port, so only selector 0 is valid
// Notes:   one command per cycle except waits; results kept by command position
// How it works
// - a wait command stalls the next command for the given milliseconds
// - line direction command changes only the addressed line of the port
// - port direction command loads the eight-bit mask, 1 output, 0 input
// - line sample stores 0 for a low line and 1 for a high line
// - each sample is stored at its command position, readable afterwards
// - line direction commands carry port and line fields; line picks one line
// - sample commands carry port and line fields naming the sampled line
// - a port write changes only lines that are outputs
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`include "sbio_map.vh"

module sbio_port #(
  parameter [31:0] CYC_PER_MS = `SBIO_MS_CYCLES
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // gpio lines
  input  wire [7:0]  gpio_in,
  output wire [7:0]  gpio_out,
  output wire [7:0]  gpio_oe
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_EXEC = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  // true when addr falls in the 16-word window starting at base
  function win_hit;
    input [7:0] addr;
    input [7:0] base;
    begin
      win_hit = ((addr & `SBIO_WIN_MASK) == base);
    end
  endfunction

  reg [31:0] script_q [0:15];
  reg [15:0] result_q;
  reg [4:0]  len_q;
  reg [4:0]  pc_q;
  reg [1:0]  state_q;
  reg        done_q;
  reg        err_q;
  reg [7:0]  dir_q;
  reg [7:0]  out_q;
  reg        aw_held_q;
  reg        w_held_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  wire       busy;
  wire       tmr_busy;
  wire       wr_fire;
  wire       go;
  wire [31:0] cmd;
  wire [3:0] opc;
  wire [3:0] port_sel;
  wire [2:0] line_sel;
  wire [15:0] arg;
  wire       exec_now;
  wire       port_ok;
  wire [31:0] wmask;

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data are caught in either order, then applied
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire       = aw_held_q && w_held_q;
  assign go = wr_fire && (awaddr_q == `SBIO_OFF_CTRL) && wstrb_q[0]
              && wdata_q[`SBIO_CTRL_START] && !busy;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q    <= 1'b0;
      w_held_q     <= 1'b0;
      awaddr_q     <= `SBIO_BYTE_ZERO;
      wdata_q      <= `SBIO_WORD_ZERO;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SBIO_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // status, pins and results are read-only; a write there is refused
        if (awaddr_q == `SBIO_OFF_CTRL || awaddr_q == `SBIO_OFF_LEN
            || win_hit(awaddr_q, `SBIO_OFF_SCRIPT))
          s_axi_bresp <= `SBIO_RESP_OKAY;
        else
          s_axi_bresp <= `SBIO_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // script store and length; frozen while a script runs so it cannot shift
  always @(posedge aclk)
  begin
    if (!aresetn)
      len_q <= 5'h00;
    else if (wr_fire && !busy && wstrb_q[0] && awaddr_q == `SBIO_OFF_LEN)
      len_q <= (wdata_q[4:0] > `SBIO_DEPTH) ? `SBIO_DEPTH : wdata_q[4:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_script
      always @(posedge aclk)
      begin
        if (!aresetn)
          script_q[gi] <= `SBIO_WORD_ZERO;
        else if (wr_fire && !busy && win_hit(awaddr_q, `SBIO_OFF_SCRIPT)
                 && awaddr_q[5:2] == gi[3:0])
          script_q[gi] <= (script_q[gi] & ~wmask) | (wdata_q & wmask);
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // command decode of the entry at the program counter
  assign busy     = (state_q != ST_IDLE);
  assign cmd      = script_q[pc_q[3:0]];
  assign opc      = cmd[`SBIO_OPC_HI:`SBIO_OPC_LO];
  assign port_sel = cmd[`SBIO_PORT_HI:`SBIO_PORT_LO];
  assign line_sel = cmd[`SBIO_LINE_HI:`SBIO_LINE_LO];
  assign arg      = cmd[`SBIO_ARG_HI:`SBIO_ARG_LO];
  assign exec_now = (state_q == ST_EXEC) && (pc_q < len_q);
  // only port 0 exists; any other selector skips the command and flags it
  assign port_ok  = (port_sel == `SBIO_PORT_ZERO);

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer: one entry per exec cycle, a wait parks in ST_WAIT
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      pc_q    <= 5'h00;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (go)
          begin
            state_q <= ST_EXEC;
            pc_q    <= 5'h00;
            done_q  <= 1'b0;
            err_q   <= 1'b0;
          end
        end
        ST_EXEC:
        begin
          if (!exec_now)
          begin
            state_q <= ST_IDLE;
            done_q  <= 1'b1;
          end
          else
          begin
            pc_q <= pc_q + 5'h01;
            if (!port_ok)
              err_q <= 1'b1;
            else if (opc == `SBIO_OP_DELAY_MS)
              state_q <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // timer busy is already high here unless the count was zero
          if (!tmr_busy)
            state_q <= ST_EXEC;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  sbio_ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (exec_now && port_ok && opc == `SBIO_OP_DELAY_MS),
    .ms_count (arg),
    .busy_q   (tmr_busy)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // per-line direction and output, per-entry sample storage
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_line
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          dir_q[gi] <= 1'b0;
          out_q[gi] <= 1'b0;
        end
        else if (exec_now && port_ok)
        begin
          if (opc == `SBIO_OP_CFG_LINE && line_sel == gi[2:0])
            dir_q[gi] <= arg[0];
          else if (opc == `SBIO_OP_CFG_PORT)
            dir_q[gi] <= arg[gi];
          // input lines keep their state whatever is written
          if (opc == `SBIO_OP_WR_PORT && dir_q[gi])
            out_q[gi] <= arg[gi];
        end
      end
    end
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_result
      always @(posedge aclk)
      begin
        if (!aresetn)
          result_q[gi] <= 1'b0;
        else if (exec_now && port_ok && opc == `SBIO_OP_RD_LINE
                 && pc_q[3:0] == gi[3:0])
          result_q[gi] <= gpio_in[line_sel];
      end
    end
  endgenerate

  assign gpio_out = out_q;
  assign gpio_oe  = dir_q;

  ////////////////////////////////////////////////////////////////////////////////
  // read channel: one outstanding read, data registered at the address edge
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `SBIO_WORD_ZERO;
      s_axi_rresp  <= `SBIO_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `SBIO_RESP_OKAY;
      s_axi_rdata  <= `SBIO_WORD_ZERO;
      if (s_axi_araddr == `SBIO_OFF_CTRL)
        s_axi_rdata <= `SBIO_WORD_ZERO;
      else if (s_axi_araddr == `SBIO_OFF_STATUS)
        s_axi_rdata <= {29'h0000_0000, err_q, done_q, busy};
      else if (s_axi_araddr == `SBIO_OFF_LEN)
        s_axi_rdata <= {27'h000_0000, len_q};
      else if (s_axi_araddr == `SBIO_OFF_PINS)
        s_axi_rdata <= {8'h00, gpio_in, out_q, dir_q};
      else if (win_hit(s_axi_araddr, `SBIO_OFF_SCRIPT))
        s_axi_rdata <= script_q[s_axi_araddr[5:2]];
      else if (win_hit(s_axi_araddr, `SBIO_OFF_RESULT))
        s_axi_rdata <= {31'h0000_0000, result_q[s_axi_araddr[5:2]]};
      else
        s_axi_rresp <= `SBIO_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // sbio_port

// ==== verification/sbio_pins_model.sv ====
// Purpose: far-side circuit on the eight gpio lines
// Assumes: lines are resistive, no contention model
// Notes:   released lines show whatever the bench puts on ext_level
module sbio_pins_model (
  // pins from the port
  input  logic [7:0] gpio_out,
  input  logic [7:0] gpio_oe,
  // level of the far circuit
  input  logic [7:0] ext_level,
  // level seen by the port
  output logic [7:0] gpio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven line reads back its own level, a released one the far side
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule // sbio_pins_model

// ==== verification/sbio_port_properties.sv ====
// Purpose: port-level checks for the scripted byte i/o port
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   bound to every sbio_port instance
module sbio_port_chk (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // register bus
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  // gpio lines
  input logic [7:0]  gpio_out,
  input logic [7:0]  gpio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // pins and bus come out of reset quiet
  chk_reset_quiet: assert property (
    $rose(aresetn) |-> gpio_oe == 8'h00 && gpio_out == 8'h00 && !s_axi_bvalid)
    else $error("outputs not cleared by reset");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  chk_b_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  // holes in the map answer with an error and zero data
  chk_rd_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:6] == 2'b11 ||
    (s_axi_araddr[7:6] == 2'b00 && s_axi_araddr[5:4] != 2'b00))
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  // an input line keeps its output value whatever is written
  chk_out_masked: assert property (
    ((gpio_out ^ $past(gpio_out)) & ~$past(gpio_oe)) == 8'h00)
    else $error("input line output value changed");
endmodule // sbio_port_chk

bind sbio_port sbio_port_chk chk_u (.*);

// ==== verification/sbio_port_test.sv ====
// Purpose: self-checking bench for the scripted byte i/o port
// Assumes: one millisecond shortened to 4 cycles
// Notes:   driver leaves notes in queues, a monitor compares answers
`include "sbio_map.vh"
module sbio_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, gpio_in, gpio_out, gpio_oe, ext_q;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [34:0] rq[$];
  logic [1:0]  bq[$];
  logic [31:0] scr[10];
  integer      n_mismatch = 0;
  integer      samples_checked = 0;
  integer      seed = 32'h81c7;

  always #2.5 aclk = ~aclk;
  sbio_port #(.CYC_PER_MS(32'd4)) dut_u (.*, .s_axi_wstrb(4'hF));
  sbio_pins_model pins_u (.*, .ext_level(ext_q));

  task automatic check(input string nm, input [34:0] seen, input [34:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic [34:0] okw(input [31:0] d);
    return {3'b000, d};
  endfunction

  // one write; the idle edge first keeps bready from toggling twice in a step
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // one read; note bit 34 marks a poll whose data is not compared
  task automatic rd(input [7:0] a, input [34:0] note);
    @(posedge aclk);
    rq.push_back(note);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
  endtask

  // answers are matched in arrival order against the oldest note
  always @(posedge aclk)
    if (aresetn)
    begin
      if (s_axi_bvalid && s_axi_bready)
        check("bresp", {33'h0, s_axi_bresp}, {33'h0, bq.pop_front()});
      if (s_axi_rvalid && s_axi_rready && !rq[0][34])
        check("rdata", {1'b0, s_axi_rresp, s_axi_rdata}, rq[0]);
      if (s_axi_rvalid && s_axi_rready)
        void'(rq.pop_front());
    end

  // a hang ends the run as a failure
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    rv = 32'h0000_0000;
    ext_q = 8'($random(seed));
    scr = '{32'h3000_000F, 32'h2005_0001, 32'h5000_00FF, 32'h2000_0000, 32'h4005_0000,
            32'h4000_0000, 32'h4006_0000, 32'h1000_0002, 32'h4006_0000, 32'h3100_00FF};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SBIO_OFF_LEN, okw(32'h0000_0000));
    rd(`SBIO_OFF_PINS, okw({8'h00, ext_q, 16'h0000}));
    for (int i = 0; i < 10; i++)
      wr(`SBIO_OFF_SCRIPT + 8'(4 * i), scr[i], `SBIO_RESP_OKAY);
    wr(`SBIO_OFF_LEN, 32'h0000_000A, `SBIO_RESP_OKAY);
    wr(`SBIO_OFF_CTRL, 32'h0000_0001, `SBIO_RESP_OKAY);
    // entry 8 samples two cycles after the 2 ms wait ends: far side flips only there
    repeat (16) @(posedge aclk);
    ext_q <= ~ext_q;
    @(posedge aclk);
    ext_q <= ~ext_q;
    for (int k = 0; k < 40 && rv[1] !== 1'b1; k++)
      rd(`SBIO_OFF_STATUS, 35'h4_0000_0000);
    rd(`SBIO_OFF_STATUS, okw(32'h0000_0006));
    rd(`SBIO_OFF_PINS, okw({8'h00, 8'h2E | (ext_q & 8'hD1), 16'h2F2E}));
    rd(`SBIO_OFF_RESULT + 8'h10, okw(32'h0000_0001));
    rd(`SBIO_OFF_RESULT + 8'h14, okw({31'h0, ext_q[0]}));
    rd(`SBIO_OFF_RESULT + 8'h18, okw({31'h0, ext_q[6]}));
    rd(`SBIO_OFF_RESULT + 8'h20, okw({31'h0, ~ext_q[6]}));
    rd(8'h20, 35'h2_0000_0000);
    wr(`SBIO_OFF_STATUS, 32'h0000_0000, `SBIO_RESP_SLVERR);
    // one more edge so the monitor has taken the last answer off its queue
    @(posedge aclk);
    check("open notes", 35'(bq.size() + rq.size()), 35'h0);
    close_out();
  end
endmodule // sbio_port_test
